// file: core/brownout_monitor_control.sv
// Purpose: control and status logic around a supply brown-out comparator
// Assumes: comparator output is asynchronous; config byte is stable at reset
// Notes:   registers on classic Wishbone, one byte per word, lane 0 only
//          a droop reset is only requested here; the reset itself comes
//          back through reset_n from the outside reset logic
//
// Contract
// - any reset loads detect enable from config
// - config detect bit is active low
// - threshold select resets to inverted config bit
// - reset enable set issues cpu reset
// - any threshold crossing sets event flag; the code sets it only while detect enable is set and warm-up has ended
// - irq while flag and both enables set
// - bit 0 reads live comparator state
// - control register at A3H, mixed access
// - interrupt path only while reset disabled
// - no re-set until supply recovers
// - rising crossing also resets when enabled
//
// The Wishbone register port was left to the implementer.

`include "brownout_monitor_regs.svh"

`timescale 1ns/1ps
`default_nettype none

module brownout_monitor_control (
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  input  wire brownout_monitor_pkg::wb_req_type wbReq,
  output logic [31:0]                           wbDatOut,
  output logic                                  wbAck,
  input  wire logic [7:0]                       brownoutConfigByte,
  input  wire logic                             supplyAboveRaw,
  output logic                                  detectEnableOut,
  output logic                                  thresholdSelectOut,
  output logic                                  cpuResetReq,
  output logic                                  droopIrqReq,
  output logic                                  irq
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hitReg(input logic [11:0] adr,
                                  input logic [9:0]  index);
    hitReg = (adr[11:2] == index);
  endfunction

  function automatic logic [31:0] widenByte(input logic [7:0] value);
    widenByte = {24'h00_0000, value};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                           detectEnable_reg;
  logic                           thresholdSelect_reg;
  logic                           resetOnDroop_reg;
  logic                           droopEventFlag_reg;
  logic [7:0]                     irqStatus_reg;
  logic [7:0]                     irqMask_reg;
  logic [7:0]                     irqEnable_reg;
  logic [7:0]                     configCopy_reg;
  logic                           syncA_reg;
  logic                           syncB_reg;
  logic                           prevStatus_reg;
  logic [1:0]                     warmup_reg;
  logic                           ack_reg;
  logic [31:0]                    datOut_reg;
  logic                           cpuReset_reg;
  logic                           droopIrq_reg;
  logic                           irq_reg;

  logic                           access;
  logic                           writeLane0;
  logic                           wrControl;
  logic                           wrStatus;
  logic                           wrMask;
  logic                           wrEnable;
  logic                           warmed;
  logic                           crossing;
  logic                           fallEdge;
  logic                           riseEdge;
  logic                           resetEvent;
  brownout_monitor_pkg::ctrl_type controlView;
  logic [7:0]                     irqEvents;
  logic [31:0]                    readData;

  // ----------------------------------------------------------------------
  // bus access decode
  // ----------------------------------------------------------------------
  // ack is taken one cycle after the request; the gap cycle keeps a held
  // request from being counted twice
  assign access     = wbReq.cyc & wbReq.stb & ~ack_reg;
  assign writeLane0 = access & wbReq.we & wbReq.sel[0];
  assign wrControl  = writeLane0 & hitReg(wbReq.adr, `CTRL_INDEX);
  assign wrStatus   = writeLane0 & hitReg(wbReq.adr, `IRQ_STATUS_INDEX);
  assign wrMask     = writeLane0 & hitReg(wbReq.adr, `IRQ_MASK_INDEX);
  assign wrEnable   = writeLane0 & hitReg(wbReq.adr, `IRQ_ENABLE_INDEX);

  // ----------------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
    end else begin
      syncA_reg <= supplyAboveRaw;
      syncB_reg <= syncA_reg;
    end
  end

  // the chain starts at zero after reset; without a warm-up a healthy
  // supply would look like a rising crossing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      warmup_reg <= `WARMUP_ZERO;
    end else if (warmup_reg != `WARMUP_CYCLES) begin
      warmup_reg <= warmup_reg + `WARMUP_STEP;
    end
  end

  assign warmed = (warmup_reg == `WARMUP_CYCLES);

  // previous status tracks even while detection is off, so enabling it
  // later does not report a stale change
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevStatus_reg <= 1'b0;
    end else begin
      prevStatus_reg <= syncB_reg;
    end
  end

  // ----------------------------------------------------------------------
  // crossing detection
  // ----------------------------------------------------------------------
  // a change of level, not the level itself, so a cleared flag stays clear
  // while the supply remains low
  assign crossing   = detectEnable_reg & warmed & (syncB_reg ^ prevStatus_reg);
  assign fallEdge   = crossing & ~syncB_reg;
  assign riseEdge   = crossing & syncB_reg;
  assign resetEvent = crossing & resetOnDroop_reg;

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // one flop per field so that every bit has a single writer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      detectEnable_reg <= ~brownoutConfigByte[`CFG_DETECT_DISABLE_BIT];
    end else if (wrControl) begin
      detectEnable_reg <= wbReq.dat[`CTRL_DETECT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thresholdSelect_reg <= ~brownoutConfigByte[`CFG_THRESHOLD_BIT];
    end else if (wrControl) begin
      thresholdSelect_reg <= wbReq.dat[`CTRL_THRESHOLD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resetOnDroop_reg <= brownoutConfigByte[`CFG_RESET_BIT];
    end else if (wrControl) begin
      resetOnDroop_reg <= wbReq.dat[`CTRL_RESET_BIT];
    end
  end

  // software may write the flag either way; a crossing in the same cycle
  // as a clearing write still leaves it set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      droopEventFlag_reg <= 1'b0;
    end else if (crossing) begin
      droopEventFlag_reg <= 1'b1;
    end else if (wrControl) begin
      droopEventFlag_reg <= wbReq.dat[`CTRL_FLAG_BIT];
    end
  end

  // reserved positions hold no storage and read as zero, so a one written
  // to bit 2 is dropped; bit 0 is the live synchronised status
  always_comb begin
    controlView.detectEnable      = detectEnable_reg;
    controlView.thresholdSelect   = thresholdSelect_reg;
    controlView.reserved5         = 1'b0;
    controlView.resetOnDroop      = resetOnDroop_reg;
    controlView.droopEventFlag    = droopEventFlag_reg;
    controlView.reserved2         = 1'b0;
    controlView.reserved1         = 1'b0;
    controlView.supplyAboveStatus = syncB_reg;
  end

  // ----------------------------------------------------------------------
  // configuration snapshot
  // ----------------------------------------------------------------------
  // loaded only while reset is held, so software sees the setting that
  // the reset values of the control register came from
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      configCopy_reg <= brownoutConfigByte;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------------
  // only the droop and global enable bits have storage; the rest read
  // as zero whatever is written
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqEnable_reg <= `REG_ZERO_BYTE;
    end else if (wrEnable) begin
      irqEnable_reg <= wbReq.dat[7:0] & `IE_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqMask_reg <= `REG_ZERO_BYTE;
    end else if (wrMask) begin
      irqMask_reg <= wbReq.dat[7:0] & `IRQ_BITS_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // sticky event status, write one to clear, set wins
  // ----------------------------------------------------------------------
  always_comb begin
    irqEvents                 = `REG_ZERO_BYTE;
    irqEvents[`IRQ_FALL_BIT]  = fallEdge;
    irqEvents[`IRQ_RISE_BIT]  = riseEdge;
    irqEvents[`IRQ_RESET_BIT] = resetEvent;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqStatus_reg <= `REG_ZERO_BYTE;
    end else if (wrStatus) begin
      irqStatus_reg <= (irqStatus_reg & ~wbReq.dat[7:0]) | irqEvents;
    end else begin
      irqStatus_reg <= irqStatus_reg | irqEvents;
    end
  end

  // ----------------------------------------------------------------------
  // outputs toward the cpu
  // ----------------------------------------------------------------------
  // the reset request is a single pulse; the reset logic outside stretches
  // it and in turn resets this block
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpuReset_reg <= 1'b0;
    end else begin
      cpuReset_reg <= resetEvent;
    end
  end

  // with reset on droop the cpu is reset instead, so the request is held
  // off; it lags the flag and enables by one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      droopIrq_reg <= 1'b0;
    end else begin
      droopIrq_reg <= droopEventFlag_reg
                    & ~resetOnDroop_reg
                    & irqEnable_reg[`IE_DROOP_BIT]
                    & irqEnable_reg[`IE_GLOBAL_BIT];
    end
  end

  // level interrupt one cycle behind the status, so a clear reaches the
  // pin a cycle after the write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // keyed on the address alone; the registered data is zeroed outside
  // read accesses, so nothing leaks onto the bus between transfers
  always_comb begin
    readData = `REG_ZERO_WORD;
    if (hitReg(wbReq.adr, `CTRL_INDEX)) begin
      readData = widenByte(controlView);
    end else if (hitReg(wbReq.adr, `IRQ_STATUS_INDEX)) begin
      readData = widenByte(irqStatus_reg);
    end else if (hitReg(wbReq.adr, `IRQ_MASK_INDEX)) begin
      readData = widenByte(irqMask_reg);
    end else if (hitReg(wbReq.adr, `IRQ_ENABLE_INDEX)) begin
      readData = widenByte(irqEnable_reg);
    end else if (hitReg(wbReq.adr, `CONFIG_INDEX)) begin
      readData = widenByte(configCopy_reg);
    end
  end

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  // unmapped addresses are acknowledged with zero data so a stray access
  // never hangs the bus
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      datOut_reg <= `REG_ZERO_WORD;
    end else if (access & ~wbReq.we) begin
      datOut_reg <= readData;
    end else begin
      datOut_reg <= `REG_ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------------
  assign wbDatOut           = datOut_reg;
  assign wbAck              = ack_reg;
  assign detectEnableOut    = detectEnable_reg;
  assign thresholdSelectOut = thresholdSelect_reg;
  assign cpuResetReq        = cpuReset_reg;
  assign droopIrqReq        = droopIrq_reg;
  assign irq                = irq_reg;

endmodule

`default_nettype wire

// file: core/brownout_monitor_regs.svh
// Purpose: offsets, bit positions and reset values of the brown-out monitor
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   offsets are register indices; byte address is four times the index
`ifndef BROWNOUT_MONITOR_REGS_SVH
`define BROWNOUT_MONITOR_REGS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define CTRL_INDEX        10'h0a3
`define IRQ_STATUS_INDEX  10'h0a4
`define IRQ_MASK_INDEX    10'h0a5
`define IRQ_ENABLE_INDEX  10'h0a6
`define CONFIG_INDEX      10'h0a7

// ----------------------------------------------------------------------
// configuration byte fields
// ----------------------------------------------------------------------
`define CFG_DETECT_DISABLE_BIT 7
`define CFG_THRESHOLD_BIT      6
`define CFG_RESET_BIT          4

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_DETECT_BIT    7
`define CTRL_THRESHOLD_BIT 6
`define CTRL_RESET_BIT     4
`define CTRL_FLAG_BIT      3

// ----------------------------------------------------------------------
// interrupt fields and reset values
// ----------------------------------------------------------------------
`define IE_DROOP_BIT   5
`define IE_GLOBAL_BIT  7
`define IE_WRITE_MASK  8'ha0
`define IRQ_FALL_BIT   0
`define IRQ_RISE_BIT   1
`define IRQ_RESET_BIT  2
`define IRQ_BITS_MASK  8'h07
`define REG_ZERO_BYTE  8'h00
`define REG_ZERO_WORD  32'h0000_0000
`define WARMUP_CYCLES  2'h3
`define WARMUP_ZERO    2'h0
`define WARMUP_STEP    2'h1

`endif

// file: core/brownout_monitor_pkg.sv
// Purpose: types shared by the brown-out monitor
// Assumes: nothing beyond the register header
// Notes:   control register layout follows its bit order, msb first
`default_nettype none
package brownout_monitor_pkg;

  // ----------------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic detectEnable;
    logic thresholdSelect;
    logic reserved5;
    logic resetOnDroop;
    logic droopEventFlag;
    logic reserved2;
    logic reserved1;
    logic supplyAboveStatus;
  } ctrl_type;

  // ----------------------------------------------------------------------
  // wishbone request group
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

endpackage
`default_nettype wire

// file: testbench/brownout_monitor_control_assertions.sv
// Purpose: port-level checks on the brown-out monitor
// Assumes: one clock, synchronous active-low reset
// Notes:   internal registers are unseen, so outputs are tied to bus and pin history
`timescale 1ns/1ps
`default_nettype none
module brownout_monitor_control_assertions (
  input wire logic                             clk,
  input wire logic                             reset_n,
  input wire brownout_monitor_pkg::wb_req_type wbReq,
  input wire logic [31:0]                      wbDatOut,
  input wire logic                             wbAck,
  input wire logic [7:0]                       brownoutConfigByte,
  input wire logic                             supplyAboveRaw,
  input wire logic                             detectEnableOut,
  input wire logic                             thresholdSelectOut,
  input wire logic                             cpuResetReq,
  input wire logic                             droopIrqReq,
  input wire logic                             irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_ack_next; wbReq.cyc && wbReq.stb && !wbAck |=> wbAck; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_single; wbAck |=> !wbAck; endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held");
  property p_dat_lane; wbDatOut[31:8] == 24'h0 && (wbAck || wbDatOut[7:0] == 8'h0); endproperty
  a_dat_lane: assert property (p_dat_lane) else $error("read data outside lane");
  property p_reserved_zero;
    wbAck && $past(wbReq.adr[11:2]) == 10'h0a3 && !$past(wbReq.we) |-> wbDatOut[5] == 1'b0 && wbDatOut[2:1] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");
  property p_ctrl_write;
    wbReq.cyc && wbReq.stb && wbReq.we && wbReq.sel[0] && !wbAck && wbReq.adr[11:2] == 10'h0a3
      |=> detectEnableOut == $past(wbReq.dat[7]) && thresholdSelectOut == $past(wbReq.dat[6]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
  property p_reset_load;
    disable iff (1'b0) !reset_n |=> detectEnableOut == !$past(brownoutConfigByte[7])
      && thresholdSelectOut == !$past(brownoutConfigByte[6]) && !cpuResetReq && !irq && !droopIrqReq && !wbAck;
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("reset values wrong");
  property p_reset_pulse; cpuResetReq |=> !cpuResetReq; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request held");
  property p_reset_cause; cpuResetReq |-> $past(supplyAboveRaw, 3) != $past(supplyAboveRaw, 4); endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset without crossing");
  property p_irq_gate; cpuResetReq |-> !droopIrqReq; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq beside reset");
endmodule
bind brownout_monitor_control brownout_monitor_control_assertions checker_i (.clk(clk), .reset_n(reset_n),
  .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck), .brownoutConfigByte(brownoutConfigByte),
  .supplyAboveRaw(supplyAboveRaw), .detectEnableOut(detectEnableOut), .thresholdSelectOut(thresholdSelectOut),
  .cpuResetReq(cpuResetReq), .droopIrqReq(droopIrqReq), .irq(irq));
`default_nettype wire

// file: testbench/brownout_comparator_model.sv
// Purpose: analog comparator and the cpu reset collector
// Assumes: the bench gives the supply in millivolts
// Notes:   no hysteresis, so the bench keeps the supply well clear of a threshold
`timescale 1ns/1ps
`default_nettype none
module brownout_comparator_model (
  input  wire logic        clk,
  input  wire logic [15:0] supplyMv,
  input  wire logic        thresholdSelect,
  input  wire logic        cpuResetReq,
  output logic             supplyAboveRaw,
  output var int           resetCount
);
  // 3.8V when select is 1, else 2.7V
  always_comb begin
    supplyAboveRaw = supplyMv > (thresholdSelect ? 16'h0ed8 : 16'h0a8c);
  end
  initial resetCount = 0;
  always @(posedge clk) begin
    if (cpuResetReq === 1'b1) begin
      resetCount <= resetCount + 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the brown-out monitor
// Assumes: crossings settle within eight cycles; bus waits end only by the watchdog
// Notes:   supply moves between 3300 and 2500 millivolts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                             clk = 1'b0;
  logic                             reset_n = 1'b0;
  brownout_monitor_pkg::wb_req_type wbReq = '0;
  logic [7:0]                       cfgByte = 8'h40;
  logic [15:0]                      supplyMv = 16'h0ce4;
  logic [31:0]                      wbDatOut;
  logic                             wbAck, rawAbove, detectEn, thrSel, cpuReset, droopIrq, irq;
  int                               resetCount;
  int                               err_total = 0;
  int                               compares = 0;
  logic [7:0]                       rd;
  always #12.5 clk = ~clk;
  brownout_monitor_control brownout_monitor_control_i (.clk(clk), .reset_n(reset_n), .wbReq(wbReq),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .brownoutConfigByte(cfgByte), .supplyAboveRaw(rawAbove),
    .detectEnableOut(detectEn), .thresholdSelectOut(thrSel), .cpuResetReq(cpuReset), .droopIrqReq(droopIrq),
    .irq(irq));
  brownout_comparator_model brownout_comparator_model_i (.clk(clk), .supplyMv(supplyMv),
    .thresholdSelect(thrSel), .cpuResetReq(cpuReset), .supplyAboveRaw(rawAbove), .resetCount(resetCount));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [3:0] sel, input logic [7:0] wd);
    wbReq <= '{1'b1, 1'b1, w, {idx, 2'b00}, sel, {24'h0, wd}};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut[7:0];
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, 4'h1, d);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 4'h1, 8'h00);
    check(rd, exp);
  endtask
  task automatic apply(input logic [7:0] c);
    reset_n <= 1'b0;
    cfgByte <= c;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic settle(input logic [15:0] mv);
    supplyMv <= mv;
    repeat (8) @(posedge clk);
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_config;
    logic [7:0] cfgs [2] = '{8'h40, 8'hd0};
    foreach (cfgs[k]) begin
      apply(cfgs[k]);
      check({7'h0, detectEn}, {7'h0, ~cfgs[k][7]});
      check({7'h0, thrSel}, {7'h0, ~cfgs[k][6]});
      rd_chk(10'h0a3, {~cfgs[k][7], ~cfgs[k][6], 1'b0, cfgs[k][4], 3'h0, 1'b1});
      rd_chk(10'h0a7, cfgs[k]);
    end
  endtask
  task automatic t_regs;
    wr(10'h0a3, 8'hfb);
    repeat (4) @(posedge clk);
    rd_chk(10'h0a3, 8'hd8);
    xfer(1'b1, 10'h0a3, 4'h0, 8'h00);
    rd_chk(10'h0a3, 8'hd8);
    wr(10'h0a3, 8'h40);
    rd_chk(10'h0a3, 8'h40);
    wr(10'h0b0, 8'hff);
    rd_chk(10'h0b0, 8'h00);
    wr(10'h0a4, 8'h07);
    rd_chk(10'h0a4, 8'h00);
  endtask
  task automatic t_droop_irq;
    logic [7:0] ies [3] = '{8'h20, 8'h80, 8'ha0};
    int base;
    apply(8'h40);
    base = resetCount;
    wr(10'h0a3, 8'h80);
    wr(10'h0a6, 8'ha0);
    wr(10'h0a5, 8'h07);
    settle(16'h09c4);
    rd_chk(10'h0a3, 8'h88);
    check({7'h0, droopIrq}, 8'h01);
    check({7'h0, irq}, 8'h01);
    rd_chk(10'h0a4, 8'h01);
    check(8'(resetCount - base), 8'h00);
    foreach (ies[k]) begin
      wr(10'h0a6, ies[k]);
      repeat (2) @(posedge clk);
      check({7'h0, droopIrq}, {7'h0, ies[k] == 8'ha0});
    end
    wr(10'h0a3, 8'h80);
    repeat (6) @(posedge clk);
    rd_chk(10'h0a3, 8'h80);
    check({7'h0, droopIrq}, 8'h00);
    wr(10'h0a4, 8'h07);
    wr(10'h0a5, 8'h00);
    settle(16'h0ce4);
    rd_chk(10'h0a3, 8'h89);
    rd_chk(10'h0a4, 8'h02);
    check({7'h0, irq}, 8'h00);
    wr(10'h0a5, 8'h02);
    repeat (2) @(posedge clk);
    check({7'h0, irq}, 8'h01);
    wr(10'h0a4, 8'h02);
    repeat (2) @(posedge clk);
    check({7'h0, irq}, 8'h00);
  endtask
  task automatic t_droop_reset;
    int base;
    base = resetCount;
    wr(10'h0a3, 8'h90);
    settle(16'h09c4);
    check(8'(resetCount - base), 8'h01);
    check({7'h0, droopIrq}, 8'h00);
    rd_chk(10'h0a3, 8'h98);
    settle(16'h0ce4);
    check(8'(resetCount - base), 8'h02);
    wr(10'h0a3, 8'h10);
    settle(16'h09c4);
    rd_chk(10'h0a3, 8'h10);
    wr(10'h0a3, 8'h90);
    repeat (6) @(posedge clk);
    check(8'(resetCount - base), 8'h02);
    rd_chk(10'h0a3, 8'h90);
  endtask
  initial begin
    t_config();
    t_regs();
    t_droop_irq();
    t_droop_reset();
    close_out();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
